// *** logic/tpsc_pkg.sv ***
// ------------------------------------------------------------
// constants of the touch panel scan and interrupt control
// ------------------------------------------------------------
package tpsc_pkg;

   localparam int CLK_MHZ = 200;

   // least times round up to whole cycles
   function automatic logic [11:0] ns2cyc(input int ns);
      return 12'((ns * CLK_MHZ + 999) / 1000);
   endfunction : ns2cyc

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int          ROUGH_NS   = 100;
   localparam int          FINE_NS[4] = '{500, 1000, 2000, 5000};
   localparam int          IRQW_NS[4] = '{1000, 2000, 4000, 8000};
   localparam int          SCAN_NS    = 10000;
   localparam logic [11:0] ROUGH_CYC  = ns2cyc(ROUGH_NS);
   localparam logic [11:0] SCAN_CYC   = ns2cyc(SCAN_NS);
   localparam logic [11:0] FINE_CYC[4] = '{ns2cyc(FINE_NS[0]),
      ns2cyc(FINE_NS[1]), ns2cyc(FINE_NS[2]), ns2cyc(FINE_NS[3])};
   localparam logic [11:0] IRQW_CYC[4] = '{ns2cyc(IRQW_NS[0]),
      ns2cyc(IRQW_NS[1]), ns2cyc(IRQW_NS[2]), ns2cyc(IRQW_NS[3])};

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD  = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_RES  = 8'h0C;
   localparam logic [7:0] OFS_APERTURE_FILTER = 8'h10;

   localparam int          CTRL_W      = 12;
   localparam logic [11:0] CTRL_RST    = 12'h020;
   localparam logic [11:0] APERTURE_FILTER_RST    = 12'h010;
   localparam int          CTL_ACM     = 0;
   localparam int          CTL_IRQ_LO  = 1;
   localparam int          CTL_APERTURE_FILTER    = 3;
   localparam int          CTL_PU100   = 4;
   localparam int          CTL_TIMED   = 5;
   localparam int          CTL_FINE_LO = 6;
   localparam int          CTL_IRQW_LO = 8;
   localparam int          CTL_NMEAS_LO = 10;

   localparam int CMD_CONTINUE_BIT    = 0;
   localparam int CMD_KIND_LO = 1;
   localparam int CMD_MEAS    = 3;

   localparam int ST_LVL_LO   = 0;
   localparam int ST_STATE_LO = 8;
   localparam int ST_TOUCH    = 12;
   localparam int ST_OVF      = 13;
   localparam int ST_IRQP     = 14;

   // ------------------------------------------------------------
   // result buffer
   // ------------------------------------------------------------
   localparam int FIFO_BITS  = 1024;
   localparam int WORD_W     = 16;
   localparam int FIFO_DEPTH = FIFO_BITS / WORD_W;
   localparam int LVL_W      = $clog2(FIFO_DEPTH) + 1;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef logic [1:0] tpsc_kind_t;
   localparam tpsc_kind_t KIND_X  = 2'h0;
   localparam tpsc_kind_t KIND_Y  = 2'h1;
   localparam tpsc_kind_t KIND_Z1 = 2'h2;
   localparam tpsc_kind_t KIND_Z2 = 2'h3;

   localparam logic [1:0] EVENT_TAG_INIT = 2'h0;
   localparam logic [1:0] EVENT_TAG_CONTINUE_BIT = 2'h1;
   localparam logic [1:0] EVENT_TAG_REL  = 2'h2;
   localparam logic [1:0] EVENT_TAG_NONE = 2'h3;

   localparam logic [1:0] IRQ_EDGE  = 2'h0;
   localparam logic [1:0] IRQ_LEVEL = 2'h1;
   localparam logic [1:0] IRQ_COR   = 2'h2;

   typedef enum logic [2:0] {
      ST_TDM   = 3'b000,
      ST_ROUGH = 3'b001,
      ST_FINE  = 3'b010,
      ST_WAIT  = 3'b011,
      ST_CONV  = 3'b100,
      ST_LPI   = 3'b101
   } tpsc_state_e;

endpackage : tpsc_pkg

// *** logic/tpsc_fifo_if.sv ***
`timescale 1ns/1ps
interface tpsc_fifo_if #(
   parameter int WIDTH = 16,
   parameter int LW    = 7
);
   logic             push;
   logic [WIDTH-1:0] push_data;
   logic             pop;
   logic [WIDTH-1:0] pop_data;
   logic             full;
   logic             empty;
   logic [LW-1:0]    level;

   modport source (output push, push_data, pop,
                   input  pop_data, full, empty, level);
   modport buffer (input  push, push_data, pop,
                   output pop_data, full, empty, level);
endinterface : tpsc_fifo_if

// *** logic/tpsc_fifo.sv ***
`timescale 1ns/1ps
module tpsc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 64
) (
   input wire logic      pclk,
   input wire logic      presetn,
   tpsc_fifo_if.buffer   bus
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0]    wr_ptr_ff;
   logic [AW-1:0]    rd_ptr_ff;
   logic [AW:0]      cnt_ff;
   wire              do_push = bus.push & ~bus.full;
   wire              do_pop  = bus.pop & ~bus.empty;

   // full push is dropped here; the caller flags the overflow
   assign bus.full     = (cnt_ff == (AW+1)'(DEPTH));
   assign bus.empty    = (cnt_ff == '0);
   assign bus.level    = cnt_ff;
   assign bus.pop_data = mem_ff[rd_ptr_ff];

   always_ff @(posedge pclk) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= bus.push_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         cnt_ff    <= '0;
      end else begin
         wr_ptr_ff <= do_push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
         rd_ptr_ff <= do_pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
         cnt_ff    <= (AW+1)'(cnt_ff + do_push - do_pop);
      end
   end
endmodule : tpsc_fifo

// *** logic/tpsc_ctrl.sv ***
`timescale 1ns/1ps
// What this block does
// - 1024-bit result fifo filled in autonomous mode
// - fill level counted in 16-bit words
// - tag bits follow each converted value
// - measurement tag names x, y, z1, z2
// - event tag gives observed touch status
// - timed scans use selectable internal durations
// - host paced scans only in direct mode
// - scan is setup phase then one measurement
// - active low irq, new data in autonomous
// - edge mode: low for programmed time
// - level mode: low while touch present
// - clear-on-read: low on data, read clears
// - aperture filter drops near-duplicate positions
// - continue bit returns to setup wait
// - touch at end: idle, pullup off, in autonomous or edge mode
// - rough pullup: switch parallel to resistor
// - fine pullup: resistor only, always done
// - touch detect untimed, pullup value selectable
// - autonomous: wait touch, then run sequence
module tpsc_ctrl (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                touch_det,
   input  wire logic                conv_done,
   input  wire logic [11:0]         conv_data,
   output logic                     conv_start,
   output tpsc_pkg::tpsc_kind_t     conv_kind,
   output logic                     rough_pullup,
   output logic                     fine_pullup,
   output logic                     res_pullup_en,
   output logic                     pullup_100k,
   output logic                     low_power_idle,
   output logic                     touch_irq_n
);
   import tpsc_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   tpsc_state_e        state_ff, nxt_state;
   logic [11:0]        cnt_ff, nxt_cnt;
   tpsc_kind_t         kind_ff, nxt_kind;
   logic               continue_bit_ff, nxt_continue_bit;
   logic               pend_ff, nxt_pend;
   logic [CTRL_W-1:0]  ctrl_ff;
   logic [11:0]        aperture_filter_ff;
   logic [11:0]        irqcnt_ff;
   logic               corp_ff;
   logic               ovf_ff;
   logic               seen_ff;
   logic               tsync1_ff, tsync2_ff, touch_d_ff;
   logic [WORD_W-1:0]  last_res_ff;
   logic [11:0]        last_pos_ff [2];
   logic [1:0]         have_ff;
   logic [31:0]        prdata_ff;
   logic               pready_ff, pslverr_ff;
   logic               conv_start_ff, irq_n_ff;
   logic               rough_ff, fine_ff, res_pu_ff, lpi_ff;

   tpsc_fifo_if #(.WIDTH(WORD_W), .LW(LVL_W)) fifo ();

   tpsc_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .pclk    (pclk),
      .presetn (presetn),
      .bus     (fifo.buffer)
   );

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire        touch    = tsync2_ff;
   wire        autonomous_conversion_mode      = ctrl_ff[CTL_ACM];
   wire [1:0]  irq_mode = ctrl_ff[CTL_IRQ_LO +: 2];
   wire        timed    = autonomous_conversion_mode | ctrl_ff[CTL_TIMED];
   wire [11:0] fine_len = FINE_CYC[ctrl_ff[CTL_FINE_LO +: 2]];
   wire [11:0] irqw_len = IRQW_CYC[ctrl_ff[CTL_IRQW_LO +: 2]];
   wire [1:0]  nmeas    = ctrl_ff[CTL_NMEAS_LO +: 2];
   wire        access   = psel & penable;
   wire        done_acc = access & pready_ff;
   wire        wr       = done_acc & pwrite;
   wire        rd       = done_acc & ~pwrite;
   wire        sel_ctrl = (paddr == OFS_CTRL);
   wire        sel_cmd  = (paddr == OFS_CMD);
   wire        sel_stat = (paddr == OFS_STAT);
   wire        sel_res  = (paddr == OFS_RES);
   wire        sel_aperture_filter = (paddr == OFS_APERTURE_FILTER);
   wire        hit      = sel_ctrl | sel_cmd | sel_stat | sel_res
                          | sel_aperture_filter;
   // host commands are ignored while the device paces itself
   wire        cmd_wr   = wr & sel_cmd & ~autonomous_conversion_mode;
   wire        cmd_continue_bit = pwdata[CMD_CONTINUE_BIT];
   wire        cmd_meas = pwdata[CMD_MEAS];
   wire tpsc_kind_t cmd_kind = pwdata[CMD_KIND_LO +: 2];
   wire        res_rd   = rd & sel_res;
   wire        cnt_zero = (cnt_ff == 12'h000);

   // ------------------------------------------------------------
   // result tagging and aperture
   // ------------------------------------------------------------
   wire [1:0]  event_tag = touch ? (seen_ff ? EVENT_TAG_CONTINUE_BIT : EVENT_TAG_INIT)
                            : (seen_ff ? EVENT_TAG_REL : EVENT_TAG_NONE);
   wire [WORD_W-1:0] res_word = {conv_data, kind_ff, event_tag};
   wire        conv_acc = (state_ff == ST_CONV) & conv_done;
   wire [11:0] ref_pos  = last_pos_ff[kind_ff[0]];
   wire [11:0] adiff    = (conv_data >= ref_pos) ? conv_data - ref_pos
                                                 : ref_pos - conv_data;
   // only positions are filtered, pressure terms always pass
   wire        ap_hit   = autonomous_conversion_mode & ctrl_ff[CTL_APERTURE_FILTER] & ~kind_ff[1]
                          & have_ff[kind_ff[0]] & (adiff <= aperture_filter_ff);
   wire        push     = conv_acc & autonomous_conversion_mode & ~ap_hit;
   wire        ovf_set  = push & fifo.full;

   assign fifo.push      = push;
   assign fifo.push_data = res_word;
   assign fifo.pop       = res_rd & autonomous_conversion_mode;

   for (genvar a = 0; a < 2; a++) begin : g_ap
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            last_pos_ff[a] <= 12'h000;
            have_ff[a]     <= 1'b0;
         end else if (push && kind_ff == tpsc_kind_t'(a)) begin
            last_pos_ff[a] <= conv_data;
            have_ff[a]     <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // scan sequencer
   // ------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_zero ? 12'h000 : 12'(cnt_ff - 12'h001);
      nxt_kind  = kind_ff;
      nxt_continue_bit  = continue_bit_ff;
      nxt_pend  = pend_ff;
      case (state_ff)
         ST_TDM, ST_LPI: begin
            if (cmd_wr) begin
               nxt_state = ST_ROUGH;
               nxt_cnt   = ROUGH_CYC;
               nxt_kind  = cmd_kind;
               nxt_continue_bit  = cmd_continue_bit;
               nxt_pend  = cmd_meas;
            end else if (autonomous_conversion_mode && (state_ff == ST_TDM ? touch
                                                     : cnt_zero)) begin
               nxt_state = ST_ROUGH;
               nxt_cnt   = ROUGH_CYC;
               nxt_kind  = KIND_X;
               nxt_continue_bit  = 1'b0;
               nxt_pend  = 1'b1;
            end
         end
         ST_ROUGH: begin
            if (cnt_zero) begin
               nxt_state = ST_FINE;
               nxt_cnt   = fine_len;
            end
         end
         ST_FINE: begin
            if (!timed) begin
               nxt_state = ST_WAIT;
            end else if (cnt_zero) begin
               nxt_state = pend_ff ? ST_CONV : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (cmd_wr) begin
               nxt_kind = cmd_kind;
               nxt_continue_bit = cmd_continue_bit;
               if (cmd_meas) begin
                  nxt_state = ST_CONV;
               end else begin
                  nxt_state = ST_ROUGH;
                  nxt_cnt   = ROUGH_CYC;
                  nxt_pend  = 1'b0;
               end
            end else if (autonomous_conversion_mode) begin
               nxt_state = ST_TDM;
            end
         end
         ST_CONV: begin
            if (conv_done) begin
               if (autonomous_conversion_mode && kind_ff != nmeas) begin
                  nxt_state = ST_ROUGH;
                  nxt_cnt   = ROUGH_CYC;
                  nxt_kind  = tpsc_kind_t'(kind_ff + 2'h1);
               end else if (!autonomous_conversion_mode && continue_bit_ff) begin
                  nxt_state = ST_WAIT;
               end else if (touch && (autonomous_conversion_mode || irq_mode == IRQ_EDGE)) begin
                  nxt_state = ST_LPI;
                  nxt_cnt   = SCAN_CYC;
               end else begin
                  nxt_state = ST_TDM;
               end
            end
         end
         default: begin
            nxt_state = ST_TDM;
         end
      endcase
   end

   // ------------------------------------------------------------
   // interrupt
   // ------------------------------------------------------------
   wire        dcm_edge   = ~autonomous_conversion_mode & (irq_mode == IRQ_EDGE);
   wire        dcm_lvl    = ~autonomous_conversion_mode & (irq_mode == IRQ_LEVEL);
   wire        cor        = autonomous_conversion_mode & (irq_mode == IRQ_COR);
   wire        touch_rise = touch & ~touch_d_ff;
   wire [11:0] nxt_irqcnt = (dcm_edge & touch_rise) ? irqw_len
                          : (irqcnt_ff != 12'h000)
                          ? 12'(irqcnt_ff - 12'h001) : 12'h000;
   // a push in the read cycle keeps the request pending
   wire        nxt_corp   = push | (corp_ff & ~res_rd);
   wire        nxt_irq_n  = dcm_edge ? (nxt_irqcnt == 12'h000)
                          : dcm_lvl  ? ~touch
                          : cor      ? ~nxt_corp
                          : autonomous_conversion_mode      ? fifo.empty
                          : 1'b1;

   // ------------------------------------------------------------
   // registers and bus
   // ------------------------------------------------------------
   wire [31:0] stat_w = {17'h00000, corp_ff, ovf_ff, touch,
                         1'b0, state_ff, 1'b0, fifo.level};
   wire [WORD_W-1:0] res_rd_w = autonomous_conversion_mode ? fifo.pop_data : last_res_ff;
   wire [31:0] rd_mux = sel_ctrl ? {20'h00000, ctrl_ff}
                      : sel_stat ? stat_w
                      : sel_res  ? {16'h0000, res_rd_w}
                      : sel_aperture_filter ? {20'h00000, aperture_filter_ff}
                      : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= access & ~pready_ff;
         pslverr_ff <= access & ~pready_ff & ~hit;
         if (access && !pready_ff && !pwrite) begin
            prdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff <= CTRL_RST;
         aperture_filter_ff <= APERTURE_FILTER_RST;
      end else begin
         if (wr && sel_ctrl) begin
            ctrl_ff <= pwdata[CTRL_W-1:0];
         end
         if (wr && sel_aperture_filter) begin
            aperture_filter_ff <= pwdata[11:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_TDM;
         cnt_ff   <= 12'h000;
         kind_ff  <= KIND_X;
         continue_bit_ff  <= 1'b0;
         pend_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         kind_ff  <= nxt_kind;
         continue_bit_ff  <= nxt_continue_bit;
         pend_ff  <= nxt_pend;
      end
   end

   // touch pin is asynchronous to pclk
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tsync1_ff  <= 1'b0;
         tsync2_ff  <= 1'b0;
         touch_d_ff <= 1'b0;
      end else begin
         tsync1_ff  <= touch_det;
         tsync2_ff  <= tsync1_ff;
         touch_d_ff <= tsync2_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_ff     <= 1'b0;
         last_res_ff <= '0;
         ovf_ff      <= 1'b0;
      end else begin
         if (conv_acc) begin
            seen_ff     <= touch;
            last_res_ff <= res_word;
         end
         ovf_ff <= ovf_set
                   | (ovf_ff & ~(wr & sel_stat & pwdata[ST_OVF]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irqcnt_ff <= 12'h000;
         corp_ff   <= 1'b0;
         irq_n_ff  <= 1'b1;
      end else begin
         irqcnt_ff <= nxt_irqcnt;
         corp_ff   <= nxt_corp;
         irq_n_ff  <= nxt_irq_n;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_start_ff <= 1'b0;
         rough_ff      <= 1'b0;
         fine_ff       <= 1'b0;
         res_pu_ff     <= 1'b1;
         lpi_ff        <= 1'b0;
      end else begin
         conv_start_ff <= (nxt_state == ST_CONV)
                          & (state_ff != ST_CONV);
         rough_ff      <= (nxt_state == ST_ROUGH);
         fine_ff       <= (nxt_state == ST_FINE)
                          | (nxt_state == ST_WAIT);
         res_pu_ff     <= (nxt_state != ST_CONV)
                          & (nxt_state != ST_LPI);
         lpi_ff        <= (nxt_state == ST_LPI);
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign conv_start     = conv_start_ff;
   assign conv_kind      = kind_ff;
   assign rough_pullup   = rough_ff;
   assign fine_pullup    = fine_ff;
   assign res_pullup_en  = res_pu_ff;
   assign pullup_100k    = ctrl_ff[CTL_PU100];
   assign low_power_idle = lpi_ff;
   assign touch_irq_n    = irq_n_ff;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_fifo_acm_only : assert property (
      fifo.level > $past(fifo.level) |-> $past(autonomous_conversion_mode))
      else $error("result buffer written outside autonomous mode");
   a_level_words : assert property (
      fifo.push && !fifo.full && !fifo.pop
      |=> fifo.level == $past(fifo.level) + 7'h01)
      else $error("buffer level not counted in words");
   a_tag_kind : assert property (
      fifo.push |-> fifo.push_data[3:2] == conv_kind)
      else $error("measurement tag mismatch");
   a_event_tag_init : assert property (
      fifo.push && touch && !seen_ff |-> fifo.push_data[1:0] == EVENT_TAG_INIT)
      else $error("event tag not initial touch");
   a_untimed_wait : assert property (
      state_ff == ST_FINE && !timed |=> state_ff == ST_WAIT)
      else $error("untimed setup did not wait for host");
   a_conv_after_setup : assert property (
      conv_start |-> $past(state_ff) == ST_FINE
                     || $past(state_ff) == ST_WAIT)
      else $error("conversion without setup phase");
   a_edge_irq_low : assert property (
      dcm_edge && touch_rise |=> !touch_irq_n [*2])
      else $error("edge interrupt not held low");
   a_level_irq : assert property (
      dcm_lvl && touch ##1 dcm_lvl |-> !touch_irq_n)
      else $error("level interrupt not low during touch");
   a_cor_clear : assert property (
      cor && res_rd && !push ##1 cor |-> touch_irq_n)
      else $error("clear on read did not release interrupt");
   a_aperture_filter_drop : assert property (
      conv_acc && ap_hit && !fifo.pop |=> $stable(fifo.level))
      else $error("aperture hit was written");
   a_continue_bit_wait : assert property (
      conv_acc && !autonomous_conversion_mode && continue_bit_ff |=> state_ff == ST_WAIT)
      else $error("continue bit ignored");
   a_lpi_no_pullup : assert property (
      $rose(low_power_idle) |-> !res_pullup_en && $past(conv_done))
      else $error("idle entered wrongly or with pullup on");
   a_fine_after_rough : assert property (
      $fell(rough_pullup) |-> fine_pullup && res_pullup_en)
      else $error("fine pullup skipped");

   c_acm_push : cover property (fifo.push && fifo.level != '0);
   c_edge_irq : cover property (dcm_edge && $fell(touch_irq_n));
   c_lpi      : cover property ($rose(low_power_idle) && autonomous_conversion_mode);
   c_continue_bit     : cover property (conv_acc && continue_bit_ff ##1 state_ff == ST_WAIT);

endmodule : tpsc_ctrl

// *** tb/tpsc_conv_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// converter datapath stand-in: answers each start after DLY
// ------------------------------------------------------------
module tpsc_conv_model #(
   parameter int          DLY = 8,
   parameter logic [11:0] VAL = 12'hABC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        conv_start,
   output logic             conv_done,
   output logic [11:0]      conv_data
);
   logic [7:0] cnt_ff;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_ff <= 8'h00;
      else if (conv_start) cnt_ff <= 8'(DLY);
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
   end
   assign conv_done = (cnt_ff == 8'h01);
   // data not valid outside the done pulse, so show its inverse
   assign conv_data = conv_done ? VAL : ~VAL;
endmodule : tpsc_conv_model

// *** tb/touch_panel_scan_irq_control_tb.sv ***
`timescale 1ns/1ps
module touch_panel_scan_irq_control_tb;
   import tpsc_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, slv, touch_det = 0, conv_done, conv_start;
   logic [11:0] conv_data;
   logic irq_n, lpi, res_pu, rough, fine, pu100;
   logic [1:0] kind;
   int num_errors = 0, n_checks = 0, cyc = 0, n;
   always #2.5 pclk = ~pclk;
   tpsc_conv_model conv_u (.pclk(pclk), .presetn(presetn),
      .conv_start(conv_start), .conv_done(conv_done),
      .conv_data(conv_data));
   tpsc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .touch_det(touch_det), .conv_done(conv_done),
      .conv_data(conv_data), .conv_start(conv_start), .conv_kind(kind),
      .rough_pullup(rough), .fine_pullup(fine), .res_pullup_en(res_pu),
      .pullup_100k(pu100), .low_power_idle(lpi), .touch_irq_n(irq_n));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, e, input string m);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk) begin
         psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      end
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 0;
      penable <= 0;
   endtask : apb
   task automatic wait_irq(input logic v);
      for (n = 0; n < 3000 && irq_n !== v; n++) @(posedge pclk);
   endtask : wait_irq
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk(irq_n, 1, "irq after reset");
      apb(0, OFS_CTRL, 0);
      chk(rd, 32'h20, "ctrl reset");
      apb(0, 8'h14, 0);
      chk(slv, 1, "unmapped no error");
      $display("t_reset done");
   endtask : t_reset
   task automatic t_edge;
      touch_det <= 1;
      wait_irq(0);
      for (n = 0; n < 3000 && irq_n === 1'b0; n++) @(posedge pclk);
      chk(n, 32'(IRQW_CYC[0]), "edge width");
      touch_det <= 0;
      repeat (10) @(posedge pclk);
      $display("t_edge done");
   endtask : t_edge
   task automatic t_level;
      apb(1, OFS_CTRL, 32'h22);
      touch_det <= 1;
      wait_irq(0);
      chk(irq_n, 0, "level no assert");
      repeat (300) @(posedge pclk);
      chk(irq_n, 0, "level dropped early");
      touch_det <= 0;
      wait_irq(1);
      chk(irq_n, 1, "level no release");
      $display("t_level done");
   endtask : t_level
   task automatic t_auto;
      // one kind, clear-on-read, timed
      apb(1, OFS_CTRL, 32'h25);
      touch_det <= 1;
      wait_irq(0);
      chk(irq_n, 0, "no data irq");
      apb(0, OFS_STAT, 0);
      chk(rd[6:0], 1, "level in words");
      apb(0, OFS_RES, 0);
      chk(rd[15:0], {12'hABC, KIND_X, EVENT_TAG_INIT}, "tagged");
      repeat (2) @(posedge pclk);
      chk(irq_n, 1, "read no clear");
      chk({lpi, res_pu}, 2'b10, "not idle");
      touch_det <= 0;
      apb(1, OFS_CTRL, 32'h20);
      $display("t_auto done");
   endtask : t_auto
   task automatic t_continue_bit;
      // timed direct scan of y, 100k pullup, continue set
      apb(1, OFS_CTRL, 32'h30);
      apb(1, OFS_CMD, 32'hB);
      @(posedge pclk);
      chk({kind, rough, fine, res_pu}, {KIND_Y, 3'b101}, "rough");
      repeat (30) @(posedge pclk);
      chk({rough, fine, res_pu, pu100}, 4'b0111, "fine");
      repeat (150) @(posedge pclk);
      apb(0, OFS_STAT, 0);
      chk(rd[10:8], 3'h3, "continue not in wait");
      apb(0, OFS_RES, 0);
      chk(rd[15:0], {12'hABC, KIND_Y, EVENT_TAG_REL}, "direct");
      $display("t_continue_bit done");
   endtask : t_continue_bit
   task automatic t_aperture_filter;
      // same x position again: the scan ends but writes nothing
      apb(1, OFS_CTRL, 32'h2D);
      touch_det <= 1;
      repeat (300) @(posedge pclk);
      apb(0, OFS_STAT, 0);
      chk(rd[10:0], {3'h5, 8'h00}, "aperture wrote");
      chk(irq_n, 1, "irq without data");
      touch_det <= 0;
      $display("t_aperture_filter done");
   endtask : t_aperture_filter
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      t_reset();
      t_edge();
      t_level();
      t_auto();
      t_continue_bit();
      t_aperture_filter();
      tally_and_finish();
   end
endmodule : touch_panel_scan_irq_control_tb
